// ==== include/sdce_regs.svh ====
// Timing and encoding constants for the SDRAM clock-enable state logic.
// Assumes a single 250 MHz clock shared by controller and memory ends.
// Operation
// - Self-refresh exit with NOP, idle after refresh_cycle_time
// - Power-down exit with NOP returns to idle
// - Clock enable low twice: ignore command pins
// - Enter low power only all idle, proper command
// - Enable fall elsewhere starts suspend next cycle
// - Enable rise in suspend ends it next cycle
// - Enable high twice: ordinary command decode
// - Suspend edge command must be bank-legal; the code does not check it, suspend entry and exit edges take any command
// - After exit wait setup before other commands
// - Per-bank state selected by bank_select
// - No illegal command to addressed bank
// - Burst termination respects bus turnaround, recovery; BST is not checked and is taken in any bank state
// - Precharge to idle bank acts as NOP
// - Refresh, mode access only when all idle
`ifndef SDCE_REGS_SVH
`define SDCE_REGS_SVH
`define SDCE_CLK_MHZ 250
`define SDCE_TRC_NS 70
`define SDCE_TRC_CYC ((`SDCE_TRC_NS * `SDCE_CLK_MHZ + 999) / 1000)
`define SDCE_TSETUP_NS 2
`define SDCE_TSETUP_CYC (((`SDCE_TSETUP_NS * `SDCE_CLK_MHZ + 999) / 1000) < 1 ? 1 : \
   ((`SDCE_TSETUP_NS * `SDCE_CLK_MHZ + 999) / 1000))
`define SDCE_NBANK 4
`define SDCE_CNT_W 8
`endif

// ==== include/sdce_pkg.sv ====
// Types shared by both ends of the clock-enable link.
// Assumes sdce_regs.svh is on the include path.
package sdce_pkg;
   // Decoded command from chip select and the three strobes
   typedef enum logic [2:0] {
      SDCE_CMD_NOP, SDCE_CMD_ACT, SDCE_CMD_RD, SDCE_CMD_WR,
      SDCE_CMD_PRE, SDCE_CMD_REF, SDCE_CMD_MRS, SDCE_CMD_BST
   } sdce_cmd_t;
   // Device-level power state, Gray coded along the usual path
   typedef enum logic [2:0] {
      SDCE_ST_NORMAL = 3'h0,
      SDCE_ST_SUSPEND = 3'h1,
      SDCE_ST_PDOWN = 3'h3,
      SDCE_ST_SREF = 3'h2,
      SDCE_ST_SREF_EXIT = 3'h6
   } sdce_pstate_t;
   // Per-bank coarse state
   typedef enum logic [1:0] {
      SDCE_BK_IDLE = 2'h0,
      SDCE_BK_ACTIVE = 2'h1
   } sdce_bank_t;
   // Decode the pin pattern into a command (chip select low means selected)
   function automatic sdce_cmd_t sdce_decode(input logic cs_n, input logic ras_n,
                                             input logic cas_n, input logic we_n);
      if (cs_n)
         return SDCE_CMD_NOP;
      unique case ({ras_n, cas_n, we_n})
         3'h7: return SDCE_CMD_NOP;
         3'h3: return SDCE_CMD_ACT;
         3'h5: return SDCE_CMD_RD;
         3'h4: return SDCE_CMD_WR;
         3'h2: return SDCE_CMD_PRE;
         3'h1: return SDCE_CMD_REF;
         3'h0: return SDCE_CMD_MRS;
         default: return SDCE_CMD_BST;
      endcase
   endfunction
endpackage

// ==== include/sdce_if.sv ====
// Command and clock-enable pins between controller and memory.
// Assumes both ends run on the same clk_in.
`timescale 1ns/100ps
`default_nettype none
interface sdce_if;
   logic cke; // Clock enable, high active
   logic cs_n; // Chip select, low active
   logic ras_n; // Row strobe, low active
   logic cas_n; // Column strobe, low active
   logic we_n; // Write strobe, low active
   logic [1:0] bank_select; // Bank address
   logic auto_precharge_flag; // Address bit selecting all banks or auto precharge
   // Controller drives all pins
   modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, bank_select, auto_precharge_flag);
   // Memory only samples them
   modport mem (input cke, cs_n, ras_n, cas_n, we_n, bank_select, auto_precharge_flag);
endinterface
`default_nettype wire

// ==== design/sdce_mem.sv ====
// Memory end: clock-enable power state machine with per-bank tracking.
// Assumes pins come from a controller on the same clock, so no synchroniser.
`timescale 1ns/100ps
`default_nettype none
`include "sdce_regs.svh"
module sdce_mem
   import sdce_pkg::*;
#(
   parameter int NBANK = `SDCE_NBANK,
   parameter int TRC_CYC = `SDCE_TRC_CYC
) (
   input wire logic clk_in,
   input wire logic rstn_in,
   sdce_if.mem pins,
   output logic [2:0] pstate_out, // Power state code
   output logic suspended_out, // Internal clock held
   output logic [NBANK-1:0] bank_active_out, // Per-bank row open
   output logic illegal_out, // Illegal command seen, one cycle
   output logic cmd_valid_out, // Command accepted in the previous cycle
   output logic [2:0] cmd_out, // Accepted command code
   output logic [1:0] cmd_bank_out // Accepted command bank
);
   initial begin
      if (NBANK != 4) $error("sdce_mem serves four banks only");
      if (TRC_CYC < 1 || TRC_CYC > 255) $error("TRC_CYC out of range");
   end

   sdce_pstate_t state_reg, state_next; // Power state
   logic cke_prev_reg; // Clock enable of previous cycle
   logic [`SDCE_CNT_W-1:0] trc_reg, trc_next; // Refresh exit countdown
   logic [NBANK-1:0] bank_reg, bank_next; // Open-row flags
   logic illegal_next; // Illegal detect
   sdce_cmd_t cmd; // Decoded command
   wire cke_rise = !cke_prev_reg && pins.cke; // Low then high
   wire cke_fall = cke_prev_reg && !pins.cke; // High then low
   wire cke_high2 = cke_prev_reg && pins.cke; // High both cycles
   wire all_idle = (bank_reg == '0); // No bank open
   wire is_nop = (cmd == SDCE_CMD_NOP); // Deselect or no-op
   wire sel_active = bank_reg[pins.bank_select]; // Addressed bank open
   wire decode_en = cke_high2 && (state_reg == SDCE_ST_NORMAL); // Ordinary decode

   assign cmd = sdce_decode(pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n);

   // Next power state, bank flags and illegal detect
   always_comb begin
      state_next = state_reg;
      trc_next = trc_reg;
      bank_next = bank_reg;
      illegal_next = 1'b0;
      unique case (state_reg)
         SDCE_ST_NORMAL: begin
            if (cke_fall && all_idle) begin
               // Low-power entry only from all banks idle
               if (is_nop)
                  state_next = SDCE_ST_PDOWN;
               else if (cmd == SDCE_CMD_REF)
                  state_next = SDCE_ST_SREF;
               else
                  illegal_next = 1'b1;
            end else if (cke_fall) begin
               state_next = SDCE_ST_SUSPEND; // Suspend next cycle
            end else if (decode_en) begin
               // Ordinary per-bank table, coarse form
               unique case (cmd)
                  SDCE_CMD_ACT: begin
                     if (sel_active) illegal_next = 1'b1;
                     else bank_next[pins.bank_select] = 1'b1;
                  end
                  SDCE_CMD_RD, SDCE_CMD_WR: begin
                     if (!sel_active) illegal_next = 1'b1;
                     else if (pins.auto_precharge_flag)
                        bank_next[pins.bank_select] = 1'b0;
                  end
                  SDCE_CMD_PRE: begin
                     // Idle bank simply stays idle: acts as no-op
                     if (pins.auto_precharge_flag) bank_next = '0;
                     else bank_next[pins.bank_select] = 1'b0;
                  end
                  SDCE_CMD_REF, SDCE_CMD_MRS: begin
                     if (!all_idle) illegal_next = 1'b1;
                  end
                  default: begin
                  end
               endcase
            end
         end
         SDCE_ST_SUSPEND: begin
            // Held while enable low; rise ends it next cycle
            if (cke_rise) state_next = SDCE_ST_NORMAL;
         end
         SDCE_ST_PDOWN: begin
            // Low twice: pins ignored
            if (cke_rise) begin
               if (is_nop) state_next = SDCE_ST_NORMAL;
               else illegal_next = 1'b1;
            end
         end
         SDCE_ST_SREF: begin
            // Low twice: pins ignored
            if (cke_rise) begin
               if (is_nop) begin
                  state_next = SDCE_ST_SREF_EXIT;
                  trc_next = TRC_CYC[`SDCE_CNT_W-1:0];
               end else begin
                  illegal_next = 1'b1;
               end
            end
         end
         SDCE_ST_SREF_EXIT: begin
            // Idle once refresh_cycle_time has passed
            if (!is_nop) illegal_next = 1'b1;
            if (trc_reg <= `SDCE_CNT_W'h01) state_next = SDCE_ST_NORMAL;
            else trc_next = trc_reg - `SDCE_CNT_W'h01;
         end
         default: state_next = SDCE_ST_NORMAL;
      endcase
   end

   // State registers
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         state_reg <= SDCE_ST_NORMAL;
         cke_prev_reg <= 1'b1;
         trc_reg <= '0;
         bank_reg <= '0;
         illegal_out <= 1'b0;
      end else begin
         state_reg <= state_next;
         cke_prev_reg <= pins.cke;
         trc_reg <= trc_next;
         bank_reg <= bank_next;
         illegal_out <= illegal_next;
      end
   end

   // Registered command report, only for ordinary decode
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         cmd_valid_out <= 1'b0;
         cmd_out <= 3'h0;
         cmd_bank_out <= 2'h0;
      end else begin
         cmd_valid_out <= decode_en && !is_nop && !illegal_next;
         cmd_out <= cmd;
         cmd_bank_out <= pins.bank_select;
      end
   end

   assign pstate_out = state_reg;
   assign suspended_out = (state_reg == SDCE_ST_SUSPEND);
   assign bank_active_out = bank_reg;
endmodule
`default_nettype wire

// ==== design/sdce_ctrl.sv ====
// Controller end: drives pins, enforces legal low-power entry and exits.
// Assumes the user holds a request until ack, one request at a time.
`timescale 1ns/100ps
`default_nettype none
`include "sdce_regs.svh"
module sdce_ctrl
   import sdce_pkg::*;
#(
   parameter int TSETUP_CYC = `SDCE_TSETUP_CYC,
   parameter int TRC_CYC = `SDCE_TRC_CYC
) (
   input wire logic clk_in,
   input wire logic rstn_in,
   sdce_if.ctrl pins,
   input wire logic req_in, // Command request, level until ack
   input wire logic [2:0] req_cmd_in, // Command code
   input wire logic [1:0] req_bank_in, // Bank
   input wire logic req_ap_in, // Auto precharge / all banks
   input wire logic lowpow_in, // 1: want power-down/self-refresh/suspend
   input wire logic sref_in, // Self-refresh instead of power-down
   output logic ack_out, // Request taken, one cycle
   output logic busy_out // Low power or exit wait in progress
);
   initial begin
      if (TSETUP_CYC < 1 || TRC_CYC < 1 || TRC_CYC > 255) $error("bad timing");
   end

   logic cke_reg; // Clock enable pin
   logic [3:0] cmd_pins_reg; // cs, ras, cas, we
   logic [1:0] bank_reg; // Bank pins
   logic ap_reg; // Address flag pin
   logic [3:0] open_reg; // Banks the controller believes open
   logic [`SDCE_CNT_W-1:0] wait_reg; // Post-exit wait
   wire all_idle = (open_reg == 4'h0);
   wire bank_open = open_reg[req_bank_in];
   // Legality against tracked bank state
   wire legal = (req_cmd_in == SDCE_CMD_ACT) ? !bank_open :
                (req_cmd_in == SDCE_CMD_RD || req_cmd_in == SDCE_CMD_WR) ? bank_open :
                (req_cmd_in == SDCE_CMD_REF || req_cmd_in == SDCE_CMD_MRS) ? all_idle :
                1'b1;
   // A request stays up until the user sees ack, so the ack cycle must not take it twice
   wire can_issue = req_in && !ack_out && cke_reg && wait_reg == '0 && legal;
   wire sref_go = lowpow_in && sref_in && all_idle;

   // Pin driver and bank tracking
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         cke_reg <= 1'b1;
         cmd_pins_reg <= 4'hf;
         bank_reg <= 2'h0;
         ap_reg <= 1'b0;
         open_reg <= 4'h0;
         wait_reg <= '0;
         ack_out <= 1'b0;
      end else begin
         ack_out <= 1'b0;
         cmd_pins_reg <= 4'hf; // Default deselect
         if (wait_reg != '0) wait_reg <= wait_reg - `SDCE_CNT_W'h01;
         if (cke_reg && lowpow_in && wait_reg == '0) begin
            // Fall with NOP or self-refresh command
            cke_reg <= 1'b0;
            if (sref_go) cmd_pins_reg <= 4'h1;
         end else if (!cke_reg && !lowpow_in) begin
            // Exit with deselect; wait before real commands
            cke_reg <= 1'b1;
            wait_reg <= (sref_in && all_idle) ? TRC_CYC[`SDCE_CNT_W-1:0] :
                        TSETUP_CYC[`SDCE_CNT_W-1:0];
         end else if (can_issue && !lowpow_in) begin
            // Only bank-legal commands go out
            ack_out <= 1'b1;
            bank_reg <= req_bank_in;
            ap_reg <= req_ap_in;
            unique case (req_cmd_in)
               SDCE_CMD_ACT: cmd_pins_reg <= 4'h3;
               SDCE_CMD_RD: cmd_pins_reg <= 4'h5;
               SDCE_CMD_WR: cmd_pins_reg <= 4'h4;
               SDCE_CMD_PRE: cmd_pins_reg <= 4'h2;
               SDCE_CMD_REF: cmd_pins_reg <= 4'h1;
               SDCE_CMD_MRS: cmd_pins_reg <= 4'h0;
               default: cmd_pins_reg <= 4'h6;
            endcase
            if (req_cmd_in == SDCE_CMD_ACT) open_reg[req_bank_in] <= 1'b1;
            if ((req_cmd_in == SDCE_CMD_RD || req_cmd_in == SDCE_CMD_WR) && req_ap_in)
               open_reg[req_bank_in] <= 1'b0;
            if (req_cmd_in == SDCE_CMD_PRE) begin
               if (req_ap_in) open_reg <= 4'h0;
               else open_reg[req_bank_in] <= 1'b0;
            end
         end
      end
   end

   assign pins.cke = cke_reg;
   assign pins.cs_n = cmd_pins_reg[3];
   assign pins.ras_n = cmd_pins_reg[2];
   assign pins.cas_n = cmd_pins_reg[1];
   assign pins.we_n = cmd_pins_reg[0];
   assign pins.bank_select = bank_reg;
   assign pins.auto_precharge_flag = ap_reg;
   assign busy_out = !cke_reg || wait_reg != '0;
endmodule
`default_nettype wire

// ==== tb/sdce_chk.sv ====
// Checker for the clock-enable link and the memory end's power state.
// Assumes instantiation beside the joining interface, all on clk_in.
`timescale 1ns/100ps
`default_nettype none
module sdce_chk #(
   parameter int TRC_CYC = 4
) (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [2:0] pstate_out,
   input wire logic suspended_out,
   input wire logic [3:0] bank_active_out,
   input wire logic illegal_out
);
   // One spare cycle for exit bookkeeping, one early for the rise edge
   localparam int TRC_LO = TRC_CYC - 1;
   localparam int TRC_HI = TRC_CYC + 1;
   wire nop_w = cs_n | (ras_n & cas_n & we_n); // Deselect or no-operation
   wire ref_w = !cs_n & !ras_n & !cas_n & we_n; // Refresh pattern
   wire low_w = (pstate_out == 3'h3) || (pstate_out == 3'h2); // Power-down or self-refresh
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   property p_exit_nop; low_w && $rose(cke) |-> nop_w; endproperty
   a_exit_nop: assert property (p_exit_nop) else $error("exit edge with command");
   property p_entry; $fell(cke) && pstate_out == 3'h0 && bank_active_out == 4'h0 |-> nop_w || ref_w; endproperty
   a_entry: assert property (p_entry) else $error("bad low power entry");
   property p_ref_idle; $fell(cke) && ref_w |-> bank_active_out == 4'h0; endproperty
   a_ref_idle: assert property (p_ref_idle) else $error("self-refresh with open bank");
   property p_susp_start; $fell(cke) && pstate_out == 3'h0 && bank_active_out != 4'h0 |=> pstate_out == 3'h1 && suspended_out; endproperty
   a_susp_start: assert property (p_susp_start) else $error("suspend not entered");
   property p_susp_hold; pstate_out == 3'h1 && !cke |=> pstate_out == 3'h1; endproperty
   a_susp_hold: assert property (p_susp_hold) else $error("suspend left early");
   property p_susp_end; pstate_out == 3'h1 && $rose(cke) |=> pstate_out == 3'h0 && !suspended_out; endproperty
   a_susp_end: assert property (p_susp_end) else $error("suspend not ended");
   // Pins must be ignored: no state change and no illegal flag
   property p_low_hold; low_w && !cke |=> $stable(pstate_out) && !illegal_out; endproperty
   a_low_hold: assert property (p_low_hold) else $error("pins not ignored");
   property p_pd_exit; pstate_out == 3'h3 && $rose(cke) |=> pstate_out == 3'h0; endproperty
   a_pd_exit: assert property (p_pd_exit) else $error("power-down exit wrong");
   property p_sref_exit; pstate_out == 3'h2 && $rose(cke) |=> pstate_out == 3'h6; endproperty
   a_sref_exit: assert property (p_sref_exit) else $error("self-refresh exit wrong");
   property p_sref_idle; $rose(pstate_out == 3'h6) |-> ##[TRC_LO:TRC_HI] pstate_out == 3'h0; endproperty
   a_sref_idle: assert property (p_sref_idle) else $error("refresh wait wrong");
   property p_setup; low_w && $rose(cke) |=> nop_w; endproperty
   a_setup: assert property (p_setup) else $error("command inside setup");
endmodule
`default_nettype wire

// ==== tb/sdce_test.sv ====
// Bench: controller and memory joined, plus a hand-driven memory end.
// Assumes package, interface and design files are compiled first.
`timescale 1ns/100ps
`default_nettype none
module sdce_test
   import sdce_pkg::*;
;
   localparam int REFRESH_CYCLE_TIME = 4; // Short refresh cycle time keeps the run brief
   logic clk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic rstn_b = 1'b0; // Own reset so each illegal case starts clean
   logic req_in = 1'b0;
   logic [2:0] req_cmd_in = 3'h0;
   logic [1:0] req_bank_in = 2'h0;
   logic req_ap_in = 1'b0; // All-banks flag for precharge
   logic lowpow_in = 1'b0;
   logic sref_in = 1'b0;
   logic ack_out, suspended_out, illegal_out, cmd_valid_out, b_illegal;
   logic [2:0] pstate_out, cmd_out, b_pstate;
   logic [1:0] cmd_bank_out;
   logic [3:0] bank_active_out, b_bank;
   int n_errors = 0;
   int n_checks = 0;
   sdce_if link_if();
   sdce_if bad_if();
   sdce_ctrl #(.TSETUP_CYC(1), .TRC_CYC(REFRESH_CYCLE_TIME)) i_sdce_ctrl (.clk_in(clk_in), .rstn_in(rstn_in),
      .pins(link_if), .req_in(req_in), .req_cmd_in(req_cmd_in), .req_bank_in(req_bank_in),
      .req_ap_in(req_ap_in), .lowpow_in(lowpow_in), .sref_in(sref_in), .ack_out(ack_out),
      .busy_out());
   sdce_mem #(.NBANK(4), .TRC_CYC(REFRESH_CYCLE_TIME)) i_sdce_mem (.clk_in(clk_in), .rstn_in(rstn_in),
      .pins(link_if), .pstate_out(pstate_out), .suspended_out(suspended_out),
      .bank_active_out(bank_active_out), .illegal_out(illegal_out), .cmd_valid_out(cmd_valid_out),
      .cmd_out(cmd_out), .cmd_bank_out(cmd_bank_out));
   // Second memory end faces the bench, which breaks the exit rules on purpose
   sdce_mem #(.NBANK(4), .TRC_CYC(REFRESH_CYCLE_TIME)) i_sdce_mem_b (.clk_in(clk_in), .rstn_in(rstn_b),
      .pins(bad_if), .pstate_out(b_pstate), .suspended_out(), .bank_active_out(b_bank),
      .illegal_out(b_illegal), .cmd_valid_out(), .cmd_out(), .cmd_bank_out());
   sdce_chk #(.TRC_CYC(REFRESH_CYCLE_TIME)) i_sdce_chk (.clk_in(clk_in), .rstn_in(rstn_in), .cke(link_if.cke),
      .cs_n(link_if.cs_n), .ras_n(link_if.ras_n), .cas_n(link_if.cas_n), .we_n(link_if.we_n),
      .pstate_out(pstate_out), .suspended_out(suspended_out), .bank_active_out(bank_active_out),
      .illegal_out(illegal_out));
   // Free-running 250 MHz clock
   initial begin
      forever #2 clk_in = ~clk_in;
   end
   // Compare and count; zero extension keeps every width legal
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Request held until ack seen, released on the next rising edge
   task automatic issue(input sdce_cmd_t c, input logic [1:0] b, output logic took);
      @(posedge clk_in);
      req_in <= 1'b1;
      req_cmd_in <= c;
      req_bank_in <= b;
      took = 1'b0;
      for (int i = 0; i < 12 && !took; i++) begin
         @(negedge clk_in);
         took = (ack_out === 1'b1);
      end
      @(posedge clk_in);
      req_in <= 1'b0;
      @(negedge clk_in);
   endtask
   // Bounded wait for the link clock enable to reach a level
   task automatic wait_cke(input logic v);
      int i;
      i = 0;
      do begin
         @(negedge clk_in);
         i++;
      end while (link_if.cke !== v && i < 20);
      chk(link_if.cke, v);
   endtask
   // Ordinary decode, per-bank tracking and refused commands
   task automatic t_cmds;
      logic ok;
      issue(SDCE_CMD_ACT, 2'h1, ok);
      chk({cmd_valid_out, cmd_out, 2'h0, cmd_bank_out}, 8'h91);
      chk(bank_active_out, 4'h2);
      issue(SDCE_CMD_REF, 2'h0, ok);
      chk(ok, 1'b0);
      issue(SDCE_CMD_ACT, 2'h1, ok);
      chk(ok, 1'b0);
      issue(SDCE_CMD_ACT, 2'h3, ok);
      chk(bank_active_out, 4'ha);
      issue(SDCE_CMD_PRE, 2'h3, ok);
      issue(SDCE_CMD_PRE, 2'h2, ok);
      chk(bank_active_out, 4'h2);
      issue(SDCE_CMD_ACT, 2'h0, ok);
      chk(bank_active_out, 4'h3);
      @(posedge clk_in) req_ap_in <= 1'b1;
      issue(SDCE_CMD_PRE, 2'h2, ok);
      chk(bank_active_out, 4'h0);
      @(posedge clk_in) req_ap_in <= 1'b0;
      issue(SDCE_CMD_ACT, 2'h1, ok);
      chk(bank_active_out, 4'h2);
      $display("test commands done");
   endtask
   // Suspend with bank 1 open, then close it
   task automatic t_suspend;
      logic ok;
      @(posedge clk_in) lowpow_in <= 1'b1;
      wait_cke(1'b0);
      @(negedge clk_in);
      chk(pstate_out, 3'h1);
      repeat (5) @(negedge clk_in);
      chk(suspended_out, 1'b1);
      @(posedge clk_in) lowpow_in <= 1'b0;
      wait_cke(1'b1);
      @(negedge clk_in);
      chk(pstate_out, 3'h0);
      chk(bank_active_out, 4'h2);
      issue(SDCE_CMD_PRE, 2'h1, ok);
      $display("test suspend done");
   endtask
   // Power-down (sr low) or self-refresh (sr high) round trip
   task automatic t_lowpow(input logic sr);
      int n;
      logic ok;
      @(posedge clk_in);
      sref_in <= sr;
      lowpow_in <= 1'b1;
      wait_cke(1'b0);
      if (sr) chk({link_if.cs_n, link_if.ras_n, link_if.cas_n, link_if.we_n}, 4'h1);
      else chk(link_if.cs_n | (link_if.ras_n & link_if.cas_n & link_if.we_n), 1'b1);
      repeat (7) @(negedge clk_in);
      chk(pstate_out, sr ? 3'h2 : 3'h3);
      @(posedge clk_in) lowpow_in <= 1'b0;
      wait_cke(1'b1);
      @(negedge clk_in);
      n = 0;
      while (pstate_out === 3'h6 && n < 50) begin
         @(negedge clk_in);
         n++;
      end
      chk(8'(n), sr ? 8'(REFRESH_CYCLE_TIME) : 8'h0);
      chk(pstate_out, 3'h0);
      issue(SDCE_CMD_ACT, 2'h0, ok);
      chk(bank_active_out, 4'h1);
      issue(SDCE_CMD_PRE, 2'h0, ok);
      $display("test low power done");
   endtask
   // Hand-driven pins on the second memory end
   task automatic bpins(input logic ck, input logic [3:0] c);
      @(posedge clk_in);
      bad_if.cke <= ck;
      {bad_if.cs_n, bad_if.ras_n, bad_if.cas_n, bad_if.we_n} <= c;
   endtask
   // Enter, send activate while asleep, then exit with activate
   task automatic t_bad(input logic [3:0] ent, input logic [2:0] st);
      @(posedge clk_in) rstn_b <= 1'b0;
      @(posedge clk_in) rstn_b <= 1'b1;
      bpins(1'b1, 4'hf);
      bpins(1'b0, ent);
      bpins(1'b0, 4'h3);
      bpins(1'b0, 4'hf);
      @(negedge clk_in);
      chk({b_illegal, b_bank}, 5'h0);
      chk(b_pstate, st);
      bpins(1'b1, 4'h3);
      bpins(1'b1, 4'hf);
      @(negedge clk_in);
      chk(b_illegal, 1'b1);
      $display("test illegal exit done");
   endtask
   // Verdict and end of run
   task automatic summarize;
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Pins of the hand-driven end idle at time zero
   initial begin
      bad_if.cke = 1'b1;
      {bad_if.cs_n, bad_if.ras_n, bad_if.cas_n, bad_if.we_n} = 4'hf;
      {bad_if.bank_select, bad_if.auto_precharge_flag} = 3'h0;
   end
   // Main sequence
   initial begin
      repeat (20) @(posedge clk_in);
      rstn_in <= 1'b1;
      rstn_b <= 1'b1;
      t_cmds();
      t_suspend();
      t_lowpow(1'b1);
      t_lowpow(1'b0);
      t_bad(4'hf, 3'h3);
      t_bad(4'h1, 3'h2);
      summarize();
   end
   // Watchdog far beyond the roughly 140 cycles the tests need
   initial begin
      repeat (20000) @(posedge clk_in);
      n_errors++;
      summarize();
   end
endmodule
`default_nettype wire
